// ### hdl/flash_boot_cmds.sv
// Boot stream, boot register, ECC status and learning pattern commands
`timescale 1ns/10ps
`default_nettype none
`include "flash_boot_map.svh"
module flash_boot_cmds #(
  parameter int          NV_WRITE_CYC  = `NV_WRITE_TIME_NS / `SYS_CLK_NS,
  parameter logic [31:0] BOOT_REG_INIT = `BOOT_REG_RESET,
  parameter logic [7:0]  PAT_INIT      = `PAT_RESET
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        soft_reset_i,
  input  wire logic        cs_n_i,
  input  wire logic        sck_i,
  input  wire logic        si_i,
  input  wire logic        quad_en_i,
  input  wire logic [7:0]  arr_data_i,
  input  wire logic [7:0]  ecc_status_i,
  input  wire logic        erase_fail_i,
  input  wire logic        prog_fail_i,
  input  wire logic        err_clear_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  output logic      [31:0] arr_addr_o,
  output logic      [31:0] ecc_addr_o,
  output logic             wel_o,
  output logic             wip_o,
  output logic             e_err_o,
  output logic             p_err_o
);
  import flash_boot_pkg::*;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic       cs_n_s;
  logic       sck_s;
  logic       si_s;
  logic       rpin_n_s;
  logic       sck_q;
  logic       cs_q;

  pin_sync #(
    .W    (4),
    .INIT (4'b1001)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({reset_pin_n_i, si_i, sck_i, cs_n_i}),
    .q_o       (pins_s)
  );

  assign cs_n_s   = pins_s[0];
  assign sck_s    = pins_s[1];
  assign si_s     = pins_s[2];
  assign rpin_n_s = pins_s[3];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
    end else begin
      sck_q <= sck_s;
      cs_q  <= cs_n_s;
    end
  end

  // Edges only count while selected; SCK may idle either way between frames
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  assign sck_rise = sck_s & ~sck_q & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_q & ~cs_n_s;
  assign cs_rise  = cs_n_s & ~cs_q;
  assign cs_fall  = ~cs_n_s & cs_q;

  // ----------------------------------------------------------------
  // Resets and configuration
  // ----------------------------------------------------------------
  logic        local_rst;
  logic [31:0] boot_reg;
  logic [31:0] boot_src;
  logic [7:0]  nv_pattern_reg;
  logic [7:0]  vol_pattern_reg;
  logic [7:0]  boot_start_delay;
  logic [31:0] boot_start_addr;

  // Power-up, reset pin and command reset all restart the boot logic
  assign local_rst = ~rst_n_i | ~rpin_n_s | soft_reset_i;
  // Nonvolatile bits hold their defaults while power-up reset is active
  assign boot_src = rst_n_i ? boot_reg : BOOT_REG_INIT;
  assign boot_start_delay = boot_reg[`BOOT_DLY_MSB:`BOOT_DLY_LSB];
  assign boot_start_addr  =
    {boot_src[`BOOT_ADDR_MSB:`BOOT_ADDR_LSB], `BOOT_ALIGN_ZERO};

  // ----------------------------------------------------------------
  // Command state
  // ----------------------------------------------------------------
  state_e      state;
  out_src_e    src;
  logic [7:0]  op;
  logic [5:0]  bit_cnt;
  logic [7:0]  dly_cnt;
  logic [31:0] sh_in;
  logic [7:0]  out_sh;
  logic [3:0]  out_left;
  logic [3:0]  byte_cnt;
  logic        started;
  logic        boot_ok;
  logic [7:0]  op_next;
  logic [7:0]  cur_byte;
  logic [7:0]  drive_byte;
  logic        quad;
  logic [3:0]  step;

  assign op_next = {sh_in[6:0], si_s};

  always_comb begin
    case (src)
      SRC_ECC:      cur_byte = ecc_status_i;
      SRC_BOOT_REG: cur_byte = boot_reg[{byte_cnt[1:0], 3'b000} +: 8];
      SRC_PAT:      cur_byte = vol_pattern_reg;
      default:      cur_byte = arr_data_i;
    endcase
  end

  assign drive_byte = (out_left == 4'h0) ? cur_byte : out_sh;
  assign quad       = (src == SRC_ARRAY) & quad_en_i;
  assign step       = quad ? 4'h4 : 4'h1;

  // ----------------------------------------------------------------
  // Write command acceptance
  // ----------------------------------------------------------------
  logic wr_end;
  logic do_write_enable_cmd;
  logic do_boot_wr;
  logic do_nv_pat;
  logic do_vol_pat;
  logic tmr_busy;
  logic tmr_done;

  // Execution only when chip select rises on the exact bit boundary
  assign wr_end     = cs_rise & (state == ST_WDATA);
  assign do_write_enable_cmd    = wr_end & (op == `OP_WRITE_ENABLE)
                    & (bit_cnt == `WRITE_ENABLE_CMD_BITS);
  assign do_boot_wr = wr_end & (op == `OP_BOOT_WR)
                    & (bit_cnt == `BOOT_WR_BITS);
  assign do_nv_pat  = wr_end & (op == `OP_NV_PAT_PROG)
                    & (bit_cnt == `PAT_WR_BITS);
  assign do_vol_pat = wr_end & (op == `OP_VOL_PAT_WR)
                    & (bit_cnt == `PAT_WR_BITS);

  // ----------------------------------------------------------------
  // Sequencer and output shifter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (local_rst) begin
      state      <= boot_src[`BOOT_EN_BIT] ? ST_BOOT_WAIT : ST_IDLE;
      arr_addr_o <= boot_start_addr;
      ecc_addr_o <= 32'h0000_0000;
      src        <= SRC_ARRAY;
      op         <= 8'h00;
      bit_cnt    <= 6'h00;
      dly_cnt    <= 8'h00;
      sh_in      <= 32'h0000_0000;
      out_sh     <= 8'h00;
      out_left   <= 4'h0;
      byte_cnt   <= 4'h0;
      started    <= 1'b0;
      boot_ok    <= 1'b0;
      io_o       <= 4'h0;
      io_oe_o    <= 4'h0;
    end else if (cs_rise) begin
      io_oe_o <= 4'h0;
      if (state == ST_BOOT_WAIT || state == ST_BOOT_DLY ||
          state == ST_BOOT_DATA) begin
        if (boot_ok) begin
          state <= ST_IDLE;
        end else begin
          // Aborted before a whole byte: stay armed from the start
          state      <= ST_BOOT_WAIT;
          arr_addr_o <= boot_start_addr;
        end
      end else begin
        state <= ST_IDLE;
      end
    end else begin
      case (state)
        ST_BOOT_WAIT: begin
          if (cs_fall) begin
            dly_cnt  <= 8'h00;
            out_left <= 4'h0;
            started  <= 1'b0;
            src      <= SRC_ARRAY;
            state    <= (boot_start_delay == 8'h00) ? ST_BOOT_DATA
                                                    : ST_BOOT_DLY;
          end
        end
        ST_BOOT_DLY: begin
          // SI is not decoded here; the host only clocks
          if (sck_rise) begin
            dly_cnt <= dly_cnt + 8'h01;
            if (dly_cnt + 8'h01 == boot_start_delay) begin
              state <= ST_BOOT_DATA;
            end
          end
        end
        ST_BOOT_DATA: begin
          if (sck_rise && started && out_left == 4'h0) begin
            boot_ok <= 1'b1;
          end
        end
        ST_IDLE: begin
          if (cs_fall) begin
            bit_cnt <= 6'h00;
            state   <= ST_OPCODE;
          end
        end
        ST_OPCODE: begin
          if (sck_rise) begin
            sh_in   <= {sh_in[30:0], si_s};
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == `OPCODE_LAST) begin
              op       <= op_next;
              bit_cnt  <= 6'h00;
              out_left <= 4'h0;
              byte_cnt <= 4'h0;
              started  <= 1'b0;
              case (op_next)
                `OP_ECC_READ: state <= ST_ADDR;
                `OP_BOOT_RD: begin
                  src   <= SRC_BOOT_REG;
                  state <= ST_OUT;
                end
                `OP_PAT_RD: begin
                  src   <= SRC_PAT;
                  state <= ST_OUT;
                end
                `OP_WRITE_ENABLE: state <= wip_o ? ST_SKIP : ST_WDATA;
                `OP_BOOT_WR, `OP_NV_PAT_PROG, `OP_VOL_PAT_WR: begin
                  state <= (wel_o && !wip_o) ? ST_WDATA : ST_SKIP;
                end
                default: state <= ST_SKIP;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            sh_in   <= {sh_in[30:0], si_s};
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == `ADDR_LAST) begin
              // Unit aligned whatever low bits the host sent
              ecc_addr_o <= {sh_in[30:4], `ECC_ALIGN_ZERO};
              bit_cnt    <= 6'h00;
              state      <= ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          if (sck_rise) begin
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == `ECC_DUMMY_LAST) begin
              src   <= SRC_ECC;
              state <= ST_OUT;
            end
          end
        end
        ST_WDATA: begin
          if (sck_rise) begin
            sh_in <= {sh_in[30:0], si_s};
            if (bit_cnt != `BIT_CNT_MAX) begin
              bit_cnt <= bit_cnt + 6'h01;
            end
          end
        end
        ST_OUT, ST_SKIP: begin
        end
        default: state <= ST_IDLE;
      endcase

      // Data changes on SCK falling edges for the host to take on rising
      if (sck_fall && (state == ST_OUT || state == ST_BOOT_DATA)) begin
        out_left <= ((out_left == 4'h0) ? 4'h8 : out_left) - step;
        if (quad) begin
          io_o    <= drive_byte[7:4];
          io_oe_o <= 4'hF;
          out_sh  <= {drive_byte[3:0], 4'h0};
        end else begin
          io_o    <= {2'b00, drive_byte[7], 1'b0};
          io_oe_o <= 4'h2;
          out_sh  <= {drive_byte[6:0], 1'b0};
        end
        if (out_left == 4'h0) begin
          started <= 1'b1;
          case (src)
            SRC_ECC: begin
              if (byte_cnt == `ECC_REPEAT_LAST) begin
                byte_cnt   <= 4'h0;
                ecc_addr_o <= ecc_addr_o + `ECC_UNIT_BYTES;
              end else begin
                byte_cnt <= byte_cnt + 4'h1;
              end
            end
            SRC_BOOT_REG: byte_cnt <= byte_cnt + 4'h1;
            SRC_PAT:      byte_cnt <= 4'h0;
            default:      arr_addr_o <= arr_addr_o + 32'h0000_0001;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-timed nonvolatile update
  // ----------------------------------------------------------------
  logic [31:0] pend_word;
  logic        pend_boot;
  logic        upd_fail;

  op_timer #(
    .CYC (NV_WRITE_CYC)
  ) u_op_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (~local_rst),
    .start_i   (do_boot_wr | do_nv_pat),
    .busy_o    (tmr_busy),
    .done_o    (tmr_done)
  );

  always_ff @(posedge clk_sys_i) begin
    if (local_rst) begin
      pend_word <= 32'h0000_0000;
      pend_boot <= 1'b0;
    end else if (do_boot_wr) begin
      // Low byte arrived first
      pend_word <= {sh_in[7:0], sh_in[15:8], sh_in[23:16], sh_in[31:24]};
      pend_boot <= 1'b1;
    end else if (do_nv_pat) begin
      pend_word <= {24'h00_0000, sh_in[7:0]};
      pend_boot <= 1'b0;
    end
  end

  // Only the boot register update has an erase phase
  assign upd_fail = prog_fail_i | (pend_boot & erase_fail_i);

  // A failed update leaves the stored value untouched
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      boot_reg       <= BOOT_REG_INIT;
      nv_pattern_reg <= PAT_INIT;
    end else if (tmr_done && !upd_fail) begin
      if (pend_boot) begin
        boot_reg <= pend_word;
      end else begin
        nv_pattern_reg <= pend_word[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (local_rst) begin
      vol_pattern_reg <= rst_n_i ? nv_pattern_reg : PAT_INIT;
    end else if (do_vol_pat) begin
      vol_pattern_reg <= sh_in[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (local_rst) begin
      wel_o   <= 1'b0;
      wip_o   <= 1'b0;
      e_err_o <= 1'b0;
      p_err_o <= 1'b0;
    end else begin
      if (do_write_enable_cmd) begin
        wel_o <= 1'b1;
      end else if (tmr_done || do_vol_pat) begin
        wel_o <= 1'b0;
      end
      if (do_boot_wr || do_nv_pat) begin
        wip_o <= 1'b1;
      end else if (tmr_done || !tmr_busy) begin
        wip_o <= 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (tmr_done && pend_boot && erase_fail_i) begin
        e_err_o <= 1'b1;
      end else if (err_clear_i) begin
        e_err_o <= 1'b0;
      end
      if (tmr_done && prog_fail_i && !(pend_boot && erase_fail_i)) begin
        p_err_o <= 1'b1;
      end else if (err_clear_i) begin
        p_err_o <= 1'b0;
      end
    end
  end
endmodule : flash_boot_cmds
`default_nettype wire

// ### hdl/flash_boot_map.svh
// Constants for the boot and register command block
`ifndef FLASH_BOOT_MAP_SVH
`define FLASH_BOOT_MAP_SVH

`define OP_WRITE_ENABLE  8'h06
`define OP_ECC_READ      8'h18
`define OP_BOOT_RD       8'h14
`define OP_BOOT_WR       8'h15
`define OP_NV_PAT_PROG   8'h43
`define OP_VOL_PAT_WR    8'h4A
`define OP_PAT_RD        8'h41

`define BOOT_ADDR_MSB    31
`define BOOT_ADDR_LSB    9
`define BOOT_DLY_MSB     8
`define BOOT_DLY_LSB     1
`define BOOT_EN_BIT      0
`define BOOT_ALIGN_ZERO  9'h000
`define BOOT_REG_RESET   32'h0000_0000
`define PAT_RESET        8'h00

`define OPCODE_LAST      6'h07
`define ADDR_LAST        6'h1F
`define ECC_DUMMY_LAST   6'h07
`define ECC_REPEAT_LAST  4'hF
`define ECC_UNIT_BYTES   32'h0000_0020
`define ECC_ALIGN_ZERO   5'h00
`define WRITE_ENABLE_CMD_BITS        6'h00
`define BOOT_WR_BITS     6'h20
`define PAT_WR_BITS      6'h08
`define BIT_CNT_MAX      6'h3F

`define SYS_CLK_NS       25
`define NV_WRITE_TIME_NS 500000

`endif

// ### hdl/flash_boot_pkg.sv
// Types shared by the boot and register command block
package flash_boot_pkg;
  typedef enum logic [3:0] {
    ST_BOOT_WAIT,
    ST_BOOT_DLY,
    ST_BOOT_DATA,
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_OUT,
    ST_WDATA,
    ST_SKIP
  } state_e;

  typedef enum logic [1:0] {
    SRC_ECC,
    SRC_BOOT_REG,
    SRC_PAT,
    SRC_ARRAY
  } out_src_e;
endpackage : flash_boot_pkg

// ### hdl/pin_sync.sv
// Two-stage synchroniser for pins from outside the system clock
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta <= INIT;
      q_o  <= INIT;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ### hdl/op_timer.sv
// Self-timed nonvolatile operation timer
`timescale 1ns/10ps
`default_nettype none
module op_timer #(
  parameter int CYC = 20000
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYC);
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] count;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      count  <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= (count == ONE);
      if (start_i) begin
        count <= LOAD;
      end else if (count != '0) begin
        count <= count - ONE;
      end
    end
  end

  assign busy_o = (count != '0);
endmodule : op_timer
`default_nettype wire

// ### dv/flash_boot_cmds_assertions.sv
// Concurrent checks on the boot and register command block
`timescale 1ns/10ps
`default_nettype none
module flash_boot_cmds_checker #(
  parameter int NV_WRITE_CYC = 20
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        reset_pin_n_i,
  input wire logic        soft_reset_i,
  input wire logic        cs_n_i,
  input wire logic        quad_en_i,
  input wire logic        erase_fail_i,
  input wire logic        prog_fail_i,
  input wire logic [3:0]  io_oe_o,
  input wire logic [31:0] arr_addr_o,
  input wire logic [31:0] ecc_addr_o,
  input wire logic        wel_o,
  input wire logic        wip_o,
  input wire logic        e_err_o,
  input wire logic        p_err_o
);
  import flash_boot_pkg::*;
  // --------------------------------------------
  // Busy length; a plain repeat would be too long
  // --------------------------------------------
  logic [31:0] busy_cnt;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !wip_o) begin
      busy_cnt <= 32'h0000_0000;
    end else begin
      busy_cnt <= busy_cnt + 32'h0000_0001;
    end
  end
  a_oe_cs_high: assert property (cs_n_i [*4] |-> io_oe_o == 4'h0)
    else $error("outputs driven with chip select high");
  a_oe_legal_code: assert property (io_oe_o inside {4'h0, 4'h2, 4'hF})
    else $error("output enable pattern not serial or quad");
  a_oe_quad_only: assert property (io_oe_o == 4'hF |-> quad_en_i)
    else $error("quad drive without quad bit");
  a_wel_after_frame: assert property ($rose(wel_o) |-> cs_n_i && $past(cs_n_i))
    else $error("latch set before frame ended");
  a_wip_after_frame: assert property ($rose(wip_o) |-> cs_n_i && $past(cs_n_i))
    else $error("busy started inside a frame");
  a_wip_wel_clear: assert property ($fell(wip_o) |-> !wel_o)
    else $error("latch still set after update");
  a_wip_bounded: assert property (wip_o |-> busy_cnt <= NV_WRITE_CYC + 2)
    else $error("busy too long");
  a_wip_full_time: assert property ($fell(wip_o) && !$past(soft_reset_i)
      && $past(reset_pin_n_i, 3) && $past(reset_pin_n_i, 4)
      |-> busy_cnt >= NV_WRITE_CYC)
    else $error("busy ended early");
  a_eerr_cause: assert property ($rose(e_err_o) |-> $fell(wip_o) && $past(erase_fail_i))
    else $error("erase error without failed update");
  a_perr_cause: assert property ($rose(p_err_o) |-> $fell(wip_o) && $past(prog_fail_i))
    else $error("program error without failed update");
  a_ecc_unit_align: assert property (ecc_addr_o[4:0] == 5'h00)
    else $error("ecc unit address not aligned");
  a_boot_addr_step: assert property (arr_addr_o != $past(arr_addr_o)
      |-> arr_addr_o == $past(arr_addr_o) + 32'h0000_0001
      || arr_addr_o[8:0] == 9'h000)
    else $error("boot address jumped");
endmodule : flash_boot_cmds_checker
bind flash_boot_cmds flash_boot_cmds_checker #(
  .NV_WRITE_CYC(NV_WRITE_CYC)
) u_checker (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reset_pin_n_i(reset_pin_n_i),
  .soft_reset_i(soft_reset_i), .cs_n_i(cs_n_i), .quad_en_i(quad_en_i),
  .erase_fail_i(erase_fail_i), .prog_fail_i(prog_fail_i),
  .io_oe_o(io_oe_o), .arr_addr_o(arr_addr_o), .ecc_addr_o(ecc_addr_o),
  .wel_o(wel_o), .wip_o(wip_o), .e_err_o(e_err_o), .p_err_o(p_err_o)
);
`default_nettype wire

// ### dv/spi_host_model.sv
// Host controller model driving the serial link
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] io_i,
  output var logic        cs_n_o,
  output var logic        sck_o,
  output var logic        si_o
);
  // ------------------
  // Frame and bit tasks
  // ------------------
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic start;
    tick(1);
    cs_n_o = 1'b0;
    tick(4);
  endtask : start
  // Clock parks low; SI flips so a stale level never looks like data
  task automatic stop;
    tick(2);
    cs_n_o = 1'b1;
    si_o   = ~si_o;
    tick(6);
  endtask : stop
  task automatic cyc(input logic b, input logic quad, output logic [3:0] r);
    si_o = b;
    tick(4);
    r = quad ? io_i : {3'b000, io_i[1]};
    sck_o = 1'b1;
    tick(4);
    sck_o = 1'b0;
  endtask : cyc
  task automatic xfer(input logic [7:0] tx, input logic quad,
                      output logic [7:0] rx);
    logic [3:0] r;
    rx = 8'h00;
    if (quad) begin
      cyc(tx[7], 1'b1, r);
      rx[7:4] = r;
      cyc(tx[3], 1'b1, r);
      rx[3:0] = r;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        cyc(tx[i], 1'b0, r);
        rx[i] = r[0];
      end
    end
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ### dv/test_flash_boot_cmds.sv
// Self-checking bench for the boot and register command block
`timescale 1ns/10ps
`default_nettype none
module test_flash_boot_cmds;
  import flash_boot_pkg::*;
  // -----------
  // Environment
  // -----------
  localparam int          NVC  = 20;
  localparam logic [31:0] INIT = 32'h0000_0A07; // Start 5, delay 3, on
  localparam logic [7:0]  PAT0 = 8'h5A;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        reset_pin_n_i = 1'b1;
  logic        soft_reset_i = 1'b0;
  logic        quad_en_i = 1'b0;
  logic        erase_fail_i = 1'b0;
  logic        prog_fail_i = 1'b0;
  logic        err_clear_i = 1'b0;
  logic        cs_n, sck, si, write_enable_latch, write_in_progress, e_err, p_err;
  logic [7:0]  arr_data, ecc_status, pat, got[$];
  logic [3:0]  io, io_oe, io_line;
  logic [31:0] arr_addr, ecc_addr, bval, ea;
  int          fail_count = 0;
  int          checks = 0;
  int          seed = 32'hfe6840dd;
  always #12.5 clk_sys_i = ~clk_sys_i;
  assign arr_data   = arr_addr[7:0] ^ 8'hA5;
  assign ecc_status = ecc_addr[12:5] ^ 8'h3C;
  // Released lines follow SCK so nothing stale reads as data
  assign io_line = (io & io_oe) | (~io_oe & {4{sck}});
  flash_boot_cmds #(.NV_WRITE_CYC(NVC), .BOOT_REG_INIT(INIT),
                    .PAT_INIT(PAT0)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reset_pin_n_i(reset_pin_n_i),
    .soft_reset_i(soft_reset_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .quad_en_i(quad_en_i), .arr_data_i(arr_data), .ecc_status_i(ecc_status),
    .erase_fail_i(erase_fail_i), .prog_fail_i(prog_fail_i),
    .err_clear_i(err_clear_i), .io_o(io), .io_oe_o(io_oe),
    .arr_addr_o(arr_addr), .ecc_addr_o(ecc_addr), .wel_o(write_enable_latch), .wip_o(write_in_progress),
    .e_err_o(e_err), .p_err_o(p_err));
  spi_host_model host (.clk_sys_i(clk_sys_i), .io_i(io_line),
                       .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  function automatic logic [7:0] boot_byte(input logic [31:0] cfg, input int k);
    logic [31:0] a;
    a = {cfg[31:9], 9'h000} + k;
    return a[7:0] ^ 8'hA5;
  endfunction : boot_byte
  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // Opcode (none for boot), address, dummies, then n bytes read back
  task automatic frame(input logic [7:0] op, input logic [31:0] ad,
                       input int na, nd, n, input logic q);
    logic [3:0] r;
    logic [7:0] b;
    host.start;
    if (op != 8'h00) host.xfer(op, 1'b0, b);
    for (int i = 0; i < na; i++) host.cyc(ad[31 - i], 1'b0, r);
    for (int i = 0; i < nd; i++) host.cyc(i[0], 1'b0, r);
    got = {};
    repeat (n) begin
      host.xfer(8'h00, q, b);
      got.push_back(b);
    end
    host.stop;
  endtask : frame
  task automatic wr(input logic [7:0] op, input logic [31:0] d, input int nb);
    logic [3:0] r;
    logic [7:0] b;
    host.start;
    host.xfer(op, 1'b0, b);
    for (int i = 0; i < nb; i++) host.cyc(d[8*(i/8) + 7 - i%8], 1'b0, r);
    host.stop;
  endtask : wr
  task automatic boot(input logic q);
    frame(8'h00, 32'h0000_0000, 0, INIT[8:1], 2, q);
    for (int i = 0; i < 2; i++) check("boot", got[i], boot_byte(INIT, i));
  endtask : boot
  task automatic rdreg(input logic [31:0] e, input int n);
    frame(8'h14, 32'h0000_0000, 0, 0, n, 1'b0);
    for (int i = 0; i < n; i++) check("bootreg", got[i], e[8*(i%4) +: 8]);
  endtask : rdreg
  task automatic rdpat(input logic [7:0] e);
    frame(8'h41, 32'h0000_0000, 0, 0, 3, 1'b0);
    for (int i = 0; i < 3; i++) check("pattern", got[i], e);
  endtask : rdpat
  task automatic wait_idle;
    for (int i = 0; i < 200 && write_in_progress === 1'b1; i++) host.tick(1);
    check("wip idle", write_in_progress, 0);
  endtask : wait_idle
  // ---------
  // Sequence
  // ---------
  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    host.tick(4);
    boot(1'b0);
    rdpat(PAT0);
    rdreg(INIT, 8);
    for (int k = 0; k < 2; k++) begin
      quad_en_i = (k == 0);
      soft_reset_i = (k == 0);
      reset_pin_n_i = (k == 0);
      host.tick(4);
      soft_reset_i = 1'b0;
      reset_pin_n_i = 1'b1;
      host.tick(8);
      boot(k == 0);
    end
    quad_en_i = 1'($random(seed));
    bval = $random(seed);
    bval[0] = 1'b0;
    wr(8'h15, bval, 32);
    rdreg(INIT, 4);
    wr(8'h06, 32'h0000_0000, 0);
    check("wel", write_enable_latch, 1);
    wr(8'h15, bval, 31);
    check("wip short", write_in_progress, 0);
    wr(8'h15, bval, 32);
    check("wip", write_in_progress, 1);
    wait_idle;
    check("wel clear", write_enable_latch, 0);
    rdreg(bval, 4);
    for (int k = 0; k < 2; k++) begin
      erase_fail_i = (k == 0);
      prog_fail_i = (k == 1);
      wr(8'h06, 32'h0000_0000, 0);
      wr(8'h15, ~bval, 32);
      wait_idle;
      check("erase err", e_err, k == 0);
      check("prog err", p_err, k == 1);
      erase_fail_i = 1'b0;
      prog_fail_i = 1'b0;
      err_clear_i = 1'b1;
      host.tick(1);
      err_clear_i = 1'b0;
    end
    rdreg(bval, 4);
    pat = $random(seed);
    wr(8'h06, 32'h0000_0000, 0);
    wr(8'h4A, {24'h00_0000, pat}, 8);
    check("wip vol", write_in_progress, 0);
    rdpat(pat);
    for (int k = 0; k < 2; k++) begin
      prog_fail_i = k[0];
      erase_fail_i = 1'($random(seed));
      wr(8'h06, 32'h0000_0000, 0);
      wr(8'h43, {24'h00_0000, ~pat}, 8);
      check("wip nv", write_in_progress, 1);
      wait_idle;
      check("wel nv", write_enable_latch, 0);
      check("prog err nv", p_err, k[0]);
      check("erase err nv", e_err, 0);
    end
    prog_fail_i = 1'b0;
    erase_fail_i = 1'b0;
    soft_reset_i = 1'b1;
    host.tick(2);
    soft_reset_i = 1'b0;
    host.tick(8);
    rdpat(~pat);
    ea = $random(seed);
    ea[4:0] = 5'h00;
    frame(8'h18, ea, 32, 8, 17, 1'b0);
    for (int i = 0; i < 17; i++) begin
      bval = (i < 16) ? ea : ea + 32'h0000_0020;
      check("ecc", got[i], bval[12:5] ^ 8'h3C);
    end
    end_sim;
  end
  initial begin
    #(25 * 80000);
    fail_count++;
    end_sim;
  end
endmodule : test_flash_boot_cmds
`default_nettype wire
